// file: design/potm_pkg.sv
/*
 Package for the pattern output trigger/mode block: register offsets, field
 positions, reset values and bus carriers. Assumes an AXI4-Lite register bus
 with 32-bit data and four timer channels with compare-match strobes.
*/
package potm_pkg;

    localparam int unsigned NUM_GROUPS = 4;
    localparam int unsigned NUM_CHANS  = 4;
    localparam int unsigned GRP_BITS   = 4;
    localparam int unsigned PAT_BITS   = NUM_GROUPS * GRP_BITS;
    localparam int unsigned SEL_W      = 2;

    // Register byte offsets
    localparam logic [7:0] OFS_TRIG_SEL  = 8'h00;
    localparam logic [7:0] OFS_OUT_MODE  = 8'h04;
    localparam logic [7:0] OFS_NEXT_BITS = 8'h08;
    localparam logic [7:0] OFS_NEXT_EN   = 8'h0C;
    localparam logic [7:0] OFS_PAT_DATA  = 8'h10;

    // Reset values
    localparam logic [7:0]  TRIG_SEL_RST  = 8'hFF;
    localparam logic [7:0]  OUT_MODE_RST  = 8'hF0;
    localparam logic [3:0]  OUT_MODE_RSVD = 4'hF;
    localparam logic [15:0] PAT_RST       = 16'h0000;

    // Field positions
    localparam int unsigned TRIG_SEL_GRP_LSB = 2;
    localparam int unsigned PAT_FOURTEEN     = 14;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic [NUM_CHANS-1:0] match_a;
        logic [NUM_CHANS-1:0] match_b;
    } potm_match_t;

    typedef struct packed {
        logic [31:0] data;
        logic [1:0]  resp;
    } potm_rd_t;

endpackage

// file: design/potm_top.sv
/*
 Pattern output trigger select and output mode block, with the next-data,
 enable and output data bits it steers. Software reaches the registers over
 AXI4-Lite. Assumes compare-match strobes come from timer logic on aclk.
*/
// Added by the designer: the placing of the registers and the AXI4-Lite register port.
//
// Overview of operation
// - Trigger select: 8-bit RW, resets all ones
// - Bits 7:6 pick group 3 channel
// - Bits 5:4 pick group 2 channel
// - Bits 3:2 pick group 1 channel
// - Bits 1:0 pick group 0 channel
// - Output mode register resets to F0
// - Mode upper nibble reserved, reads ones
// - Mode bit 3: group 3 non-overlap
// - Mode bit 2: group 2 non-overlap
// - Mode bit 1: group 1 non-overlap
// - Mode bit 0: group 0 non-overlap
// - Bit fourteen kept internally, never driven out
// - Non-overlap: A copies all, B zeros
// - Disabled bits never copied on trigger
`timescale 1ns/1ps

module potm_top
(
    input  wire logic                  aclk,            // Peripheral clock
    input  wire logic                  aresetn,         // Sync reset, active low
    input  wire logic                  hw_standby,      // Hardware standby entry
    input  wire logic [3:0]            cmp_match_a,     // Match A strobes per channel
    input  wire logic [3:0]            cmp_match_b,     // Match B strobes per channel
    input  wire logic                  s_axi_awvalid,   // Write address valid
    output logic                       s_axi_awready,   // Write address ready
    input  wire logic [7:0]            s_axi_awaddr,    // Write address
    input  wire logic                  s_axi_wvalid,    // Write data valid
    output logic                       s_axi_wready,    // Write data ready
    input  wire logic [31:0]           s_axi_wdata,     // Write data
    input  wire logic [3:0]            s_axi_wstrb,     // Write strobes
    output logic                       s_axi_bvalid,    // Write response valid
    input  wire logic                  s_axi_bready,    // Write response ready
    output logic [1:0]                 s_axi_bresp,     // Write response
    input  wire logic                  s_axi_arvalid,   // Read address valid
    output logic                       s_axi_arready,   // Read address ready
    input  wire logic [7:0]            s_axi_araddr,    // Read address
    output logic                       s_axi_rvalid,    // Read data valid
    input  wire logic                  s_axi_rready,    // Read data ready
    output logic [31:0]                s_axi_rdata,     // Read data
    output logic [1:0]                 s_axi_rresp,     // Read response
    output logic [14:0]                pattern_pins     // Pins, bit 14 absent
);

    logic                 clr;
    potm_pkg::potm_match_t match;
    logic [7:0]           pattern_trigger_select;
    logic [3:0]           nonoverlap_mode;
    logic [15:0]          next_pattern_bits;
    logic [15:0]          next_pattern_enable;
    logic [15:0]          pattern_data;
    logic [15:0]          next_pattern_data;

    logic                 aw_held;
    logic                 w_held;
    logic [7:0]           aw_addr;
    logic [31:0]          w_data;
    logic [3:0]           w_strb;

    // Hardware standby clears like reset; software standby has no effect
    assign clr = !aresetn || hw_standby;
    assign match.match_a = cmp_match_a;
    assign match.match_b = cmp_match_b;

    // Write channel: address and data taken in either order
    wire aw_take  = s_axi_awvalid && s_axi_awready;
    wire w_take   = s_axi_wvalid && s_axi_wready;
    wire do_write = aw_held && w_held && !s_axi_bvalid;
    wire wr_lane0 = do_write && w_strb[0];
    wire wr_lane1 = do_write && w_strb[1];

    wire hit_sel  = aw_addr == potm_pkg::OFS_TRIG_SEL;
    wire hit_mode = aw_addr == potm_pkg::OFS_OUT_MODE;
    wire hit_nb   = aw_addr == potm_pkg::OFS_NEXT_BITS;
    wire hit_ne   = aw_addr == potm_pkg::OFS_NEXT_EN;
    wire hit_pd   = aw_addr == potm_pkg::OFS_PAT_DATA;
    wire wr_known = hit_sel || hit_mode || hit_nb || hit_ne || hit_pd;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            aw_held       <= 1'b0;
            w_held        <= 1'b0;
            aw_addr       <= 8'h00;
            w_data        <= 32'h0000_0000;
            w_strb        <= 4'h0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= potm_pkg::RESP_OKAY;
        end
        else
        begin
            if (aw_take)
            begin
                aw_held       <= 1'b1;
                aw_addr       <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (w_take)
            begin
                w_held       <= 1'b1;
                w_data       <= s_axi_wdata;
                w_strb       <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (do_write)
            begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_known ? potm_pkg::RESP_OKAY : potm_pkg::RESP_SLVERR;
                aw_held      <= 1'b0;
                w_held       <= 1'b0;
            end
            if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // Configuration registers; only byte lanes 0 and 1 carry bits
    always_ff @(posedge aclk)
    begin
        if (clr)
        begin
            pattern_trigger_select <= potm_pkg::TRIG_SEL_RST;
            nonoverlap_mode        <= potm_pkg::OUT_MODE_RST[3:0];
            next_pattern_bits      <= potm_pkg::PAT_RST;
            next_pattern_enable    <= potm_pkg::PAT_RST;
        end
        else
        begin
            if (wr_lane0 && hit_sel)
                pattern_trigger_select <= w_data[7:0];
            if (wr_lane0 && hit_mode)
                nonoverlap_mode <= w_data[3:0];
            if (wr_lane0 && hit_nb)
                next_pattern_bits[7:0] <= w_data[7:0];
            if (wr_lane1 && hit_nb)
                next_pattern_bits[15:8] <= w_data[15:8];
            if (wr_lane0 && hit_ne)
                next_pattern_enable[7:0] <= w_data[7:0];
            if (wr_lane1 && hit_ne)
                next_pattern_enable[15:8] <= w_data[15:8];
        end
    end

    // Per-group trigger routing and transfer
    genvar g;
    generate
        for (g = 0; g < potm_pkg::NUM_GROUPS; g++)
        begin : gen_grp
            localparam int unsigned LO = g * potm_pkg::GRP_BITS;
            wire [1:0] sel   = pattern_trigger_select[g*potm_pkg::SEL_W +: potm_pkg::SEL_W];
            wire       hit_a = match.match_a[sel];
            wire       hit_b = match.match_b[sel];
            wire       nov   = nonoverlap_mode[g];
            wire [3:0] nb    = next_pattern_bits[LO +: potm_pkg::GRP_BITS];
            wire [3:0] en    = next_pattern_enable[LO +: potm_pkg::GRP_BITS];
            wire [3:0] cur   = pattern_data[LO +: potm_pkg::GRP_BITS];
            // Match B only lets zeros through, so falls lead the rises at A
            wire [3:0] copy  = hit_a ? en : ((nov && hit_b) ? (en & ~nb) : 4'h0);
            wire [3:0] sw_wr = (hit_pd && (g < 2 ? wr_lane0 : wr_lane1)) ? ~en : 4'h0;
            // Enabled bits are read-only to software; hardware transfer wins
            assign next_pattern_data[LO +: potm_pkg::GRP_BITS] =
                (copy & nb) | (~copy & sw_wr & w_data[LO +: potm_pkg::GRP_BITS])
                | (~copy & ~sw_wr & cur);
        end
    endgenerate

    always_ff @(posedge aclk)
    begin
        if (clr)
        begin
            pattern_data <= potm_pkg::PAT_RST;
            pattern_pins <= 15'h0000;
        end
        else
        begin
            pattern_data <= next_pattern_data;
            // Bit fourteen stays in pattern_data but has no pin
            pattern_pins <= {next_pattern_data[15], next_pattern_data[13:0]};
        end
    end

    // Read channel, one read at a time
    wire [31:0] rd_word =
        (s_axi_araddr == potm_pkg::OFS_TRIG_SEL)  ? {24'h000000, pattern_trigger_select} :
        (s_axi_araddr == potm_pkg::OFS_OUT_MODE)  ?
            {24'h000000, potm_pkg::OUT_MODE_RSVD, nonoverlap_mode} :
        (s_axi_araddr == potm_pkg::OFS_NEXT_BITS) ? {16'h0000, next_pattern_bits} :
        (s_axi_araddr == potm_pkg::OFS_NEXT_EN)   ? {16'h0000, next_pattern_enable} :
        (s_axi_araddr == potm_pkg::OFS_PAT_DATA)  ? {16'h0000, pattern_data} : 32'h0000_0000;
    wire rd_known = (s_axi_araddr == potm_pkg::OFS_TRIG_SEL)
                 || (s_axi_araddr == potm_pkg::OFS_OUT_MODE)
                 || (s_axi_araddr == potm_pkg::OFS_NEXT_BITS)
                 || (s_axi_araddr == potm_pkg::OFS_NEXT_EN)
                 || (s_axi_araddr == potm_pkg::OFS_PAT_DATA);
    potm_pkg::potm_rd_t rd;
    assign rd.data = rd_word;
    assign rd.resp = rd_known ? potm_pkg::RESP_OKAY : potm_pkg::RESP_SLVERR;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= potm_pkg::RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd.data;
            s_axi_rresp   <= rd.resp;
        end
        else if (s_axi_rvalid && s_axi_rready)
        begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

endmodule

// file: tb/potm_timer_model.sv
/* Timer-side model: one-cycle compare-match strobes per channel.
   Requests come from the bench, changed just after aclk edges. */
`timescale 1ns/1ps
module potm_timer_model (
    input  wire logic             aclk,   // clock
    input  wire logic [1:0]       chan,   // channel
    input  wire logic             fire_a, // want match A
    input  wire logic             fire_b, // want match B
    output potm_pkg::potm_match_t match   // strobes
);
    initial match = '0;
    always @(posedge aclk)
    begin
        match.match_a <= fire_a ? 4'h1 << chan : 4'h0;
        match.match_b <= fire_b ? 4'h1 << chan : 4'h0;
    end
endmodule

// file: tb/potm_top_sva.sv
/* Checker for potm_top: bus answers, reserved mode bits, pin causes.
   Sees only top ports; one aclk domain, synchronous reset. */
`timescale 1ns/1ps
module potm_top_sva (
    input wire logic        aclk,          // clock
    input wire logic        aresetn,       // reset
    input wire logic        hw_standby,    // standby
    input wire logic [3:0]  cmp_match_a,   // match A
    input wire logic [3:0]  cmp_match_b,   // match B
    input wire logic        s_axi_bvalid,  // b valid
    input wire logic        s_axi_bready,  // b ready
    input wire logic        s_axi_arvalid, // ar valid
    input wire logic        s_axi_arready, // ar ready
    input wire logic [7:0]  s_axi_araddr,  // ar addr
    input wire logic        s_axi_rvalid,  // r valid
    input wire logic        s_axi_rready,  // r ready
    input wire logic [31:0] s_axi_rdata,   // r data
    input wire logic [1:0]  s_axi_rresp,   // r resp
    input wire logic [14:0] pattern_pins   // pins
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    wire ar_hs = s_axi_arvalid && s_axi_arready;
    property p_bh; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
    a_bh: assert property (p_bh) else $error("bvalid dropped");
    property p_rh; s_axi_rvalid && !s_axi_rready |=> $stable(s_axi_rdata); endproperty
    a_rh: assert property (p_rh) else $error("rdata moved");
    property p_ra; ar_hs |=> s_axi_rvalid; endproperty
    a_ra: assert property (p_ra) else $error("read late");
    property p_rsv; ar_hs && s_axi_araddr == 8'h04 |=> s_axi_rdata[7:4] == 4'hF; endproperty
    a_rsv: assert property (p_rsv) else $error("mode top bits");
    property p_err; ar_hs && s_axi_araddr > 8'h10 |=> s_axi_rresp == 2'h2; endproperty
    a_err: assert property (p_err) else $error("unmapped ok");
    property p_ok; ar_hs && s_axi_araddr == 8'h00 |=> s_axi_rresp == 2'h0; endproperty
    a_ok: assert property (p_ok) else $error("mapped err");
    // Pins move only on a strobe, standby or a finished write
    property p_pin; $changed(pattern_pins) |->
        $past(|{cmp_match_a, cmp_match_b, hw_standby}) || $rose(s_axi_bvalid); endproperty
    a_pin: assert property (p_pin) else $error("pins moved");
    property p_sb; hw_standby ##1 hw_standby |=> pattern_pins == 15'h0000; endproperty
    a_sb: assert property (p_sb) else $error("standby pins");
endmodule
bind potm_top potm_top_sva u_sva (.aclk(aclk), .aresetn(aresetn), .hw_standby(hw_standby),
    .cmp_match_a(cmp_match_a), .cmp_match_b(cmp_match_b), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .pattern_pins(pattern_pins));

// file: tb/tb_pattern_output_trigger_mode.sv
/* Bench for potm_top: AXI4-Lite register access, trigger routing, modes,
   standby. Expects potm_timer_model to supply the strobes. */
`timescale 1ns/1ps
module tb_pattern_output_trigger_mode;
    logic        aclk = 1'b0, aresetn = 1'b0, hw_standby = 1'b0, fire_a = 1'b0, fire_b = 1'b0;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  chan = 2'h0, bresp, rresp;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00, sel;
    logic [31:0] wdata = 32'h0, rdata;
    logic [14:0] pins;
    logic [15:0] exp_pat, nxt, en;
    logic [3:0]  mode;
    int          err_total = 0, check_count = 0;
    potm_pkg::potm_match_t match;
    potm_timer_model tmr (.aclk(aclk), .chan(chan), .fire_a(fire_a), .fire_b(fire_b), .match(match));
    potm_top uut (.aclk(aclk), .aresetn(aresetn), .hw_standby(hw_standby),
        .cmp_match_a(match.match_a), .cmp_match_b(match.match_b), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_bresp(bresp), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .pattern_pins(pins));
    initial forever #50 aclk = ~aclk;
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e)
        begin
            err_total++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic aw_ok = 1'b0, w_ok = 1'b0;
        @(posedge aclk);
        awvalid <= 1'b1;
        awaddr <= a;
        wvalid <= 1'b1;
        wdata <= d;
        bready <= 1'b1;
        while (!(aw_ok && w_ok))
        begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            aw_ok = aw_ok | awready;
            w_ok = w_ok | wready;
        end
        do @(posedge aclk); while (!bvalid);
        bready <= 1'b0;
        chk("bresp", a > 8'h10 ? 32'h2 : 32'h0, {30'h0, bresp});
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        @(posedge aclk);
        arvalid <= 1'b1;
        araddr <= a;
        rready <= 1'b1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge aclk); while (!rvalid);
        rready <= 1'b0;
        chk("rdata", e, rdata);
        chk("rresp", a > 8'h10 ? 32'h2 : 32'h0, {30'h0, rresp});
    endtask
    task automatic cfg(input logic [7:0] s, input logic [3:0] m, input logic [15:0] n, e);
        sel = s;
        mode = m;
        nxt = n;
        en = e;
        wr(potm_pkg::OFS_TRIG_SEL, {24'h0, s});
        wr(potm_pkg::OFS_OUT_MODE, {28'h0, m});
        wr(potm_pkg::OFS_NEXT_BITS, {16'h0, n});
        wr(potm_pkg::OFS_NEXT_EN, {16'h0, e});
        rd_chk(potm_pkg::OFS_TRIG_SEL, {24'h0, s});
        rd_chk(potm_pkg::OFS_OUT_MODE, {24'h0, 4'hF, m});
    endtask
    task automatic fire(input logic [1:0] c, input logic is_a);
        logic [3:0] m;
        @(posedge aclk);
        chan <= c;
        fire_a <= is_a;
        fire_b <= !is_a;
        @(posedge aclk);
        fire_a <= 1'b0;
        fire_b <= 1'b0;
        repeat (2) @(posedge aclk);
        for (int g = 0; g < 4; g++)
        begin
            m = en[4*g+:4] & (is_a ? 4'hF : (mode[g] ? ~nxt[4*g+:4] : 4'h0));
            if (sel[2*g+:2] == c) exp_pat[4*g+:4] = (exp_pat[4*g+:4] & ~m) | (nxt[4*g+:4] & m);
        end
        chk("pins", {17'h0, exp_pat[15], exp_pat[13:0]}, {17'h0, pins});
        rd_chk(potm_pkg::OFS_PAT_DATA, {16'h0, exp_pat});
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial
    begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        exp_pat = 16'h0000;
        rd_chk(potm_pkg::OFS_TRIG_SEL, 32'hFF);
        rd_chk(potm_pkg::OFS_OUT_MODE, 32'hF0);
        rd_chk(8'h14, 32'h0);
        // Each group sees every channel code once
        for (int c = 0; c < 4; c++)
        begin
            cfg({2'(c + 3), 2'(c + 2), 2'(c + 1), 2'(c)}, 4'h0, 16'hC3A5 ^ 16'(c * 'h1111), 16'hFFFF);
            for (int k = 0; k < 4; k++) fire(2'(k), 1'b1);
        end
        for (int i = 0; i < 2; i++)
        begin
            cfg(8'h00, i ? 4'hA : 4'h5, ~exp_pat, 16'hF0FF);
            fire(2'h0, 1'b0);
            fire(2'h0, 1'b1);
        end
        hw_standby <= 1'b1;
        repeat (3) @(posedge aclk);
        hw_standby <= 1'b0;
        rd_chk(potm_pkg::OFS_TRIG_SEL, 32'hFF);
        rd_chk(potm_pkg::OFS_OUT_MODE, 32'hF0);
        chk("pins", 32'h0, {17'h0, pins});
        // Enables cleared by standby, so software owns every data bit
        wr(potm_pkg::OFS_PAT_DATA, 32'h0000_BEEF);
        rd_chk(potm_pkg::OFS_PAT_DATA, 32'hBEEF);
        chk("pins", {17'h0, 1'b1, 14'h3EEF}, {17'h0, pins});
        wr(8'h14, 32'h0000_0000);
        // Second reset in mid-run clears the data bits and pins
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rd_chk(potm_pkg::OFS_PAT_DATA, 32'h0);
        chk("pins", 32'h0, {17'h0, pins});
        print_verdict();
    end
    initial
    begin
        repeat (5000) @(posedge aclk);
        err_total++;
        print_verdict();
    end
endmodule
